// file: logic/dpio_top.sv
// Address decode and interrupt routing for a two-port serial adapter
// Functional notes
// - Each enabled port answers only its eight-address window at its base.
// - Each port has its own independent base selector.
// - Three selector bits map to 3F8,2F8,3E8,2E8,2A0,300,328.
// - Selector bit three enables the port; off means no decode.
// - Each port steers its request to one chosen line, or none.
// - Ports naming the same line in shared mode may share it.
// - Defaults: port one 3F8 on IRQ4, port two 2F8 on IRQ3.
// - Normal drives alone; shared cooperates; one master pulls line down.
`timescale 1ns/1ps
`default_nettype none
module dpio_top
#(
  parameter dpio_pkg::dpio_cfg_type PORT1_DEFAULT = '{dpio_pkg::SW1_DEFAULT,
                                       dpio_pkg::ROUTE_IRQ4, dpio_pkg::DPIO_MODE_NORMAL},
  parameter dpio_pkg::dpio_cfg_type PORT2_DEFAULT = '{dpio_pkg::SW2_DEFAULT,
                                       dpio_pkg::ROUTE_IRQ3, dpio_pkg::DPIO_MODE_NORMAL}
)
(
  input  wire logic                              clk,
  input  wire logic                              rst,
  input  wire logic                              cfg_load,
  input  wire dpio_pkg::dpio_cfg_type            port1_cfg,
  input  wire dpio_pkg::dpio_cfg_type            port2_cfg,
  input  wire logic [dpio_pkg::ADDR_W-1:0]       io_addr,
  input  wire logic                              io_rd,
  input  wire logic                              io_wr,
  input  wire logic [dpio_pkg::NPORTS-1:0]       port_irq,
  output logic [dpio_pkg::NPORTS-1:0]            port_cs,
  output logic [dpio_pkg::LOW_BITS-1:0]          port_reg_sel,
  output logic [dpio_pkg::IRQ_LINES-1:0]         irq_out,
  output logic [dpio_pkg::IRQ_LINES-1:0]         irq_oe_n,
  output logic [dpio_pkg::IRQ_LINES-1:0]         irq_pulldown
);

  // ------------------------------------------------------------
  // Configuration
  // ------------------------------------------------------------
  dpio_pkg::dpio_cfg_type cfg_reg [dpio_pkg::NPORTS];

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cfg_reg[0] <= PORT1_DEFAULT;
      cfg_reg[1] <= PORT2_DEFAULT;
    end
    else if (cfg_load)
    begin
      cfg_reg[0] <= port1_cfg;
      cfg_reg[1] <= port2_cfg;
    end
  end

  // ------------------------------------------------------------
  // Base selection
  // ------------------------------------------------------------
  function automatic logic [dpio_pkg::ADDR_W:0] base_of(input logic [3:0] sel);
    logic [dpio_pkg::ADDR_W:0] r;
    r = '0;
    if (sel[dpio_pkg::SW_EN_BIT])
    begin
      unique case (sel[dpio_pkg::SEL_W-1:0])
        dpio_pkg::SEL_3F8: r = {1'b1, dpio_pkg::BASE_3F8};
        dpio_pkg::SEL_2F8: r = {1'b1, dpio_pkg::BASE_2F8};
        dpio_pkg::SEL_3E8: r = {1'b1, dpio_pkg::BASE_3E8};
        dpio_pkg::SEL_2E8: r = {1'b1, dpio_pkg::BASE_2E8};
        dpio_pkg::SEL_2A0: r = {1'b1, dpio_pkg::BASE_2A0};
        dpio_pkg::SEL_300: r = {1'b1, dpio_pkg::BASE_300};
        dpio_pkg::SEL_328: r = {1'b1, dpio_pkg::BASE_328};
        default:           r = '0;
      endcase
    end
    return r;
  endfunction

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  logic [dpio_pkg::NPORTS-1:0] hit;

  genvar gp;
  generate
    for (gp = 0; gp < dpio_pkg::NPORTS; gp++)
    begin : g_dec
      logic [dpio_pkg::ADDR_W:0] b;
      assign b = base_of(cfg_reg[gp].base_sel);
      assign hit[gp] = b[dpio_pkg::ADDR_W] && (io_rd || io_wr) &&
                       (io_addr[dpio_pkg::ADDR_W-1:dpio_pkg::LOW_BITS] ==
                        b[dpio_pkg::ADDR_W-1:dpio_pkg::LOW_BITS]);
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      port_cs      <= '0;
      port_reg_sel <= '0;
    end
    else
    begin
      port_cs      <= hit;
      port_reg_sel <= io_addr[dpio_pkg::LOW_BITS-1:0];
    end
  end

  // ------------------------------------------------------------
  // Interrupt routing
  // ------------------------------------------------------------
  logic [dpio_pkg::IRQ_LINES-1:0] drv_n, lvl, pd;

  always_comb
  begin
    drv_n = '1;
    lvl   = '0;
    pd    = '0;
    for (int p = 0; p < dpio_pkg::NPORTS; p++)
    begin
      if (cfg_reg[p].route != dpio_pkg::ROUTE_NONE)
      begin
        if (cfg_reg[p].mode == dpio_pkg::DPIO_MODE_NORMAL)
        begin
          drv_n[cfg_reg[p].route] = 1'b0;
          lvl[cfg_reg[p].route]   = lvl[cfg_reg[p].route] | port_irq[p];
        end
        else
        begin
          if (port_irq[p])
          begin
            drv_n[cfg_reg[p].route] = 1'b0;
            lvl[cfg_reg[p].route]   = 1'b1;
          end
          if (cfg_reg[p].mode == dpio_pkg::DPIO_MODE_MASTER)
            pd[cfg_reg[p].route] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      irq_out      <= '0;
      irq_oe_n     <= '1;
      irq_pulldown <= '0;
    end
    else
    begin
      irq_out      <= lvl;
      irq_oe_n     <= drv_n;
      irq_pulldown <= pd;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_cs_window;
    @(posedge clk) disable iff (rst)
      port_cs[0] |-> $past(g_dec[0].b[dpio_pkg::ADDR_W]) &&
        ($past(io_addr[dpio_pkg::ADDR_W-1:dpio_pkg::LOW_BITS]) ==
         $past(g_dec[0].b[dpio_pkg::ADDR_W-1:dpio_pkg::LOW_BITS]));
  endproperty
  a_cs_window: assert property (p_cs_window) else $error("cs outside window");

  property p_disabled;
    @(posedge clk) disable iff (rst)
      !$past(cfg_reg[0].base_sel[dpio_pkg::SW_EN_BIT]) |-> !port_cs[0];
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled port selected");

  property p_sel_pass;
    @(posedge clk) disable iff (rst)
      ##1 port_reg_sel == $past(io_addr[dpio_pkg::LOW_BITS-1:0]);
  endproperty
  a_sel_pass: assert property (p_sel_pass) else $error("reg select wrong");

  property p_no_route;
    @(posedge clk) disable iff (rst)
      (cfg_reg[0].route == dpio_pkg::ROUTE_NONE && cfg_reg[1].route == dpio_pkg::ROUTE_NONE)
        ##1 (cfg_reg[0].route == dpio_pkg::ROUTE_NONE) |-> irq_oe_n == '1;
  endproperty
  a_no_route: assert property (p_no_route) else $error("unrouted irq driven");

  property p_default;
    @(posedge clk) $fell(rst) |-> cfg_reg[0].route == dpio_pkg::ROUTE_IRQ4 &&
      cfg_reg[1].base_sel == dpio_pkg::SW2_DEFAULT;
  endproperty
  a_default: assert property (p_default) else $error("bad defaults");

  // ------------------------------------------------------------
  // Interrupt checks
  // ------------------------------------------------------------
  sequence s_port0_request;
    (cfg_reg[0].route != dpio_pkg::ROUTE_NONE) && port_irq[0];
  endsequence

  sequence s_port0_line_high;
    irq_out[$past(cfg_reg[0].route)] && !irq_oe_n[$past(cfg_reg[0].route)];
  endsequence

  property p_route_drive;
    @(posedge clk) disable iff (rst)
      s_port0_request |=> s_port0_line_high;
  endproperty
  a_route_drive: assert property (p_route_drive) else $error("request not on line");

  property p_normal_drive;
    @(posedge clk) disable iff (rst)
      (cfg_reg[1].mode == dpio_pkg::DPIO_MODE_NORMAL) &&
      (cfg_reg[1].route != dpio_pkg::ROUTE_NONE) |=> !irq_oe_n[$past(cfg_reg[1].route)];
  endproperty
  a_normal_drive: assert property (p_normal_drive) else $error("normal line released");

  property p_master_pd;
    @(posedge clk) disable iff (rst)
      (cfg_reg[1].mode == dpio_pkg::DPIO_MODE_MASTER) &&
      (cfg_reg[1].route != dpio_pkg::ROUTE_NONE) |=> irq_pulldown[$past(cfg_reg[1].route)];
  endproperty
  a_master_pd: assert property (p_master_pd) else $error("master pull-down missing");
endmodule
`default_nettype wire

// file: include/dpio_pkg.sv
// Package for the dual-port I/O address decode and IRQ routing block
`default_nettype none
package dpio_pkg;
  localparam int          ADDR_W      = 10;
  localparam int          SEL_W       = 3;
  localparam int          ROUTE_W     = 3;
  localparam int          IRQ_LINES   = 8;
  localparam int          NPORTS      = 2;
  localparam int          LOW_BITS    = 3;
  localparam int          SW_EN_BIT   = 3;
  // Base addresses
  localparam logic [9:0]  BASE_3F8    = 10'h3F8;
  localparam logic [9:0]  BASE_2F8    = 10'h2F8;
  localparam logic [9:0]  BASE_3E8    = 10'h3E8;
  localparam logic [9:0]  BASE_2E8    = 10'h2E8;
  localparam logic [9:0]  BASE_2A0    = 10'h2A0;
  localparam logic [9:0]  BASE_300    = 10'h300;
  localparam logic [9:0]  BASE_328    = 10'h328;
  // Switch codes, bit set means switch On; bit 0 is position 1
  localparam logic [2:0]  SEL_3F8     = 3'h7;
  localparam logic [2:0]  SEL_2F8     = 3'h3;
  localparam logic [2:0]  SEL_3E8     = 3'h5;
  localparam logic [2:0]  SEL_2E8     = 3'h1;
  localparam logic [2:0]  SEL_2A0     = 3'h6;
  localparam logic [2:0]  SEL_300     = 3'h2;
  localparam logic [2:0]  SEL_328     = 3'h4;
  // Route selector: 0 none, else IRQ line number
  localparam logic [2:0]  ROUTE_NONE  = 3'h0;
  localparam logic [2:0]  ROUTE_IRQ3  = 3'h3;
  localparam logic [2:0]  ROUTE_IRQ4  = 3'h4;
  localparam logic [3:0]  SW1_DEFAULT = 4'hF;
  localparam logic [3:0]  SW2_DEFAULT = 4'hB;

  typedef enum logic [1:0]
  {
    DPIO_MODE_NORMAL = 2'h0,
    DPIO_MODE_SHARED = 2'h1,
    DPIO_MODE_MASTER = 2'h3
  } dpio_mode_type;

  typedef struct packed
  {
    logic [3:0]    base_sel;
    logic [2:0]    route;
    dpio_mode_type mode;
  } dpio_cfg_type;
endpackage
`default_nettype wire

// file: bench/dpio_host.sv
// Host I/O bus and interrupt source model
`timescale 1ns/1ps
`default_nettype none
module dpio_host
(
  input  wire logic                        clk,
  output var  logic [dpio_pkg::ADDR_W-1:0] io_addr,
  output var  logic                        io_rd,
  output var  logic                        io_wr,
  output var  logic [dpio_pkg::NPORTS-1:0] port_irq
);
  initial
  begin
    io_addr = 10'h000;
    io_rd = 1'h0;
    io_wr = 1'h0;
    port_irq = 2'h0;
  end
  // One access cycle; address scrambled once released
  task automatic io_access(input logic [9:0] a, input logic w);
    @(posedge clk);
    io_addr <= a;
    io_rd <= !w;
    io_wr <= w;
    @(posedge clk);
    io_rd <= 1'h0;
    io_wr <= 1'h0;
    io_addr <= ~a;
  endtask
  task automatic set_irq(input logic [1:0] v);
    @(posedge clk);
    port_irq <= v;
  endtask
endmodule
`default_nettype wire

// file: bench/testbench.sv
// Self-checking bench for the decode and routing block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic cfg_load = 1'h0;
  dpio_pkg::dpio_cfg_type c1 = '0;
  dpio_pkg::dpio_cfg_type c2 = '0;
  logic [9:0] addr;
  logic rd, wr;
  logic [1:0] pirq, cs;
  logic [2:0] rsel;
  logic [7:0] iout, ioe, ipd;
  int n_fail = 0;
  int checked = 0;
  int cyc = 0;
  logic [9:0] bases [7] = '{10'h3F8, 10'h2F8, 10'h3E8, 10'h2E8, 10'h2A0, 10'h300, 10'h328};
  logic [2:0] sels [7] = '{3'h7, 3'h3, 3'h5, 3'h1, 3'h6, 3'h2, 3'h4};
  dpio_host i_dpio_host (.clk(clk), .io_addr(addr), .io_rd(rd), .io_wr(wr), .port_irq(pirq));
  dpio_top i_dpio_top (.clk(clk), .rst(rst), .cfg_load(cfg_load), .port1_cfg(c1),
    .port2_cfg(c2), .io_addr(addr), .io_rd(rd), .io_wr(wr), .port_irq(pirq),
    .port_cs(cs), .port_reg_sel(rsel), .irq_out(iout), .irq_oe_n(ioe), .irq_pulldown(ipd));
  initial
  begin
    forever #4 clk = ~clk;
  end
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      n_fail++;
      tally_and_finish();
    end
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  function automatic dpio_pkg::dpio_cfg_type mk(input logic [3:0] s, input logic [2:0] r,
    input dpio_pkg::dpio_mode_type m);
    mk = '{s, r, m};
  endfunction
  task automatic cfg(input dpio_pkg::dpio_cfg_type a, input dpio_pkg::dpio_cfg_type b);
    @(posedge clk);
    cfg_load <= 1'h1;
    c1 <= a;
    c2 <= b;
    @(posedge clk);
    cfg_load <= 1'h0;
  endtask
  task automatic acc(input logic [9:0] a, input logic [1:0] e);
    i_dpio_host.io_access(a, a[0]);
    #1;
    chk("port_cs", {6'h00, e}, {6'h00, cs});
    if (e != 2'h0)
      chk("port_reg_sel", {5'h00, a[2:0]}, {5'h00, rsel});
  endtask
  task automatic ichk(input logic [1:0] p, input logic [7:0] o, input logic [7:0] oe,
    input logic [7:0] pd);
    i_dpio_host.set_irq(p);
    repeat (2) @(posedge clk);
    #1;
    chk("irq_out", o, iout);
    chk("irq_oe_n", oe, ioe);
    chk("irq_pulldown", pd, ipd);
  endtask
  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'h0;
    acc(10'h3FB, 2'h1);
    acc(10'h2FF, 2'h2);
    acc(10'h3F7, 2'h0);
    acc(10'h300, 2'h0);
    ichk(2'h1, 8'h10, 8'hE7, 8'h00);
    $display("defaults done");
    for (int i = 0; i < 7; i++)
    begin
      cfg(mk({1'h1, sels[i]}, (sels[i] == 3'h3) ? 3'h3 : 3'h4, dpio_pkg::DPIO_MODE_NORMAL),
        mk({1'h1, sels[(i + 1) % 7]}, (sels[(i + 1) % 7] == 3'h7) ? 3'h4 : 3'h3,
        dpio_pkg::DPIO_MODE_NORMAL));
      acc(bases[i], 2'h1);
      acc(bases[i] + 10'h007, 2'h1);
      acc(bases[i] - 10'h001, 2'h0);
      acc(bases[(i + 1) % 7] + 10'h002, 2'h2);
    end
    $display("decode done");
    cfg(mk(4'h7, 3'h0, dpio_pkg::DPIO_MODE_NORMAL),
      mk(4'hE, 3'h0, dpio_pkg::DPIO_MODE_NORMAL));
    acc(10'h3F8, 2'h0);
    acc(10'h2A0, 2'h2);
    ichk(2'h3, 8'h00, 8'hFF, 8'h00);
    cfg(mk(4'hF, 3'h4, dpio_pkg::DPIO_MODE_NORMAL),
      mk(4'hE, 3'h0, dpio_pkg::DPIO_MODE_NORMAL));
    ichk(2'h3, 8'h10, 8'hEF, 8'h00);
    cfg(mk(4'hF, 3'h4, dpio_pkg::DPIO_MODE_SHARED),
      mk(4'hD, 3'h4, dpio_pkg::DPIO_MODE_MASTER));
    ichk(2'h0, 8'h00, 8'hFF, 8'h10);
    ichk(2'h1, 8'h10, 8'hEF, 8'h10);
    ichk(2'h2, 8'h10, 8'hEF, 8'h10);
    ichk(2'h3, 8'h10, 8'hEF, 8'h10);
    $display("irq done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
